// File: rtl/mbfe_map.svh
// Constant definitions for the host bus front end.
`ifndef MBFE_MAP_SVH
`define MBFE_MAP_SVH
`define MBFE_BYTE_W 8
`define MBFE_ADDR_W 16
`define MBFE_HOST_WR_STROBE 2'h0
`define MBFE_HOST_RW_DIR 2'h1
`define MBFE_HOST_DS 2'h2
`define MBFE_HOST_FETCH_RD 2'h3
`define MBFE_ADDR_RST 16'h0000
`define MBFE_DATA_RST 8'h00
`define MBFE_SYNC_W 6
`endif

// File: rtl/mbfe_pkg.sv
// Types for the host bus front end: the host type shared by both ends and the state type of the host end.
package mbfe_pkg;
  typedef logic [1:0] mbfe_host_t;
  typedef enum logic [3:0] {
    MBFE_IDLE = 4'h1,
    MBFE_ADDR = 4'h2,
    MBFE_RD   = 4'h4,
    MBFE_WR   = 4'h8
  } mbfe_state_t;
endpackage

// File: rtl/mbfe_bus_if.sv
// Interface joining the host and device ends of the bus.
`timescale 1ns/10ps
interface mbfe_bus_if;
  logic [7:0] lower_addr_data_port_h;
  logic       lower_oe_h;
  logic [7:0] upper_addr_data_port_h;
  logic       upper_oe_h;
  logic [7:0] lower_addr_data_port_d;
  logic [7:0] upper_addr_data_port_d;
  logic       data_oe_d;
  logic       addr_latch;
  logic       write_control_input;
  logic       read_control_input;
  logic       fetch_control_input;
  logic       rst_n;
  // Device sees host drive; host sees device drive during reads.
  modport host (
    output lower_addr_data_port_h, lower_oe_h, upper_addr_data_port_h,
    output upper_oe_h, addr_latch, write_control_input,
    output read_control_input, fetch_control_input, rst_n,
    input  lower_addr_data_port_d, upper_addr_data_port_d, data_oe_d
  );
  modport device (
    input  lower_addr_data_port_h, lower_oe_h, upper_addr_data_port_h,
    input  upper_oe_h, addr_latch, write_control_input,
    input  read_control_input, fetch_control_input, rst_n,
    output lower_addr_data_port_d, upper_addr_data_port_d, data_oe_d
  );
endinterface

// File: rtl/mbfe_device.sv
// Device end: address capture, strobe decoding and read drive control.
// Contract
// - Host puts low address/data on lower port.
// - Host puts address bits 8-15 on upper port.
// - Device latches address by latch/strobe input.
// - Drive ports only on read with selection.
// - Captured address feeds programmable logic decode.
// - First control is write strobe or direction.
// - Second control is read, data or fetch.
// - Control inputs feed programmable logic equations.
// - Third control is fetch or generic input.
// - Burst hosts wire bits 4-19 across ports.
// - Paged hosts put upper address/data upper.
// - Reset reinitialises ports, macrocells, configuration.
// - System holds reset low during power-up.
// - Reset aborts flash program or erase.
// - Strobe style captures at strobe rising edge.
`timescale 1ns/10ps
`include "mbfe_map.svh"
module mbfe_device (
  // Clock and internal reset.
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  // Bus pins.
  mbfe_bus_if.device              bus,
  // Host type selection.
  input  wire mbfe_pkg::mbfe_host_t host_type_in,
  input  wire logic               strobe_style_in,
  // Internal block side.
  input  wire logic               block_select_in,
  input  wire logic [7:0]         read_data_in,
  input  wire logic               flash_busy_in,
  output logic [15:0]             pld_addr_out,
  output logic [7:0]              write_data_out,
  output logic                    write_pulse_out,
  output logic                    read_active_out,
  output logic                    fetch_active_out,
  output logic                    generic_in_out,
  output logic [2:0]              pld_ctrl_out,
  output logic                    flash_abort_out,
  output logic                    port_reset_out
);
  // Two-stage synchronisers for every pin input the device reads; stage one is read only
  // by stage two.
  logic [`MBFE_SYNC_W-1:0] sync1, sync2;
  logic [7:0] lo1, lo2, hi1, hi2;
  logic [`MBFE_SYNC_W-1:0] pin_vec;
  assign pin_vec = {bus.rst_n, bus.fetch_control_input,
                    bus.read_control_input, bus.write_control_input,
                    bus.addr_latch, 1'b0};
  always_ff @(posedge mclk_in) begin
    sync1 <= pin_vec;
    sync2 <= sync1;
    lo1   <= bus.lower_addr_data_port_h;
    lo2   <= lo1;
    hi1   <= bus.upper_addr_data_port_h;
    hi2   <= hi1;
  end

  logic ale_s, wr_s, rd_s, fe_s, rstn_s;
  assign ale_s  = sync2[1];
  assign wr_s   = sync2[2];
  assign rd_s   = sync2[3];
  assign fe_s   = sync2[4];
  assign rstn_s = sync2[5];

  // Combined reset: internal reset or the active-low pin.
  logic rst_all;
  assign rst_all = rst_in | ~rstn_s;

  // Decode of the write strobe according to host type.
  function automatic logic is_write(input mbfe_pkg::mbfe_host_t ht,
                                    input logic c0, input logic c1);
    if (ht == `MBFE_HOST_RW_DIR || ht == `MBFE_HOST_DS) begin
      is_write = ~c0 & ~c1;
    end else begin
      is_write = ~c0;
    end
  endfunction

  // Decode of the read strobe; DS hosts qualify with direction high.
  function automatic logic is_read(input mbfe_pkg::mbfe_host_t ht,
                                   input logic c0, input logic c1,
                                   input logic c2);
    if (ht == `MBFE_HOST_RW_DIR || ht == `MBFE_HOST_DS) begin
      is_read = c0 & ~c1;
    end else if (ht == `MBFE_HOST_FETCH_RD) begin
      is_read = ~c1 | ~c2;
    end else begin
      is_read = ~c1;
    end
  endfunction

  logic rd_act, wr_act;
  assign rd_act = is_read(host_type_in, wr_s, rd_s, fe_s);
  assign wr_act = is_write(host_type_in, wr_s, rd_s);

  // Address latch state plus previous strobe levels for edges.
  logic [15:0] addr, next_addr;
  logic        ale_d, next_ale_d;
  logic        wr_d, next_wr_d;
  logic [7:0]  wdata, next_wdata;
  logic        wpulse, next_wpulse;

  // Strobe style latches on rising edge; latch style is transparent while
  // high and holds from the fall, which keeps the address for the cycle.
  always_comb begin
    next_addr   = addr;
    next_ale_d  = ale_s;
    next_wr_d   = wr_act;
    next_wdata  = wdata;
    next_wpulse = 1'b0;
    if (strobe_style_in) begin
      if (ale_s && !ale_d) begin
        next_addr = {hi2, lo2};
      end
    end else if (ale_s) begin
      next_addr = {hi2, lo2};
    end
    // Data written on the strobe's trailing edge, when data is stable.
    if (!wr_act && wr_d) begin
      next_wpulse = 1'b1;
    end
    if (wr_act) begin
      next_wdata = lo2;
    end
    if (rst_all) begin
      next_addr   = `MBFE_ADDR_RST;
      next_wdata  = `MBFE_DATA_RST;
      next_wpulse = 1'b0;
      next_wr_d   = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    addr   <= next_addr;
    ale_d  <= next_ale_d;
    wr_d   <= next_wr_d;
    wdata  <= next_wdata;
    wpulse <= next_wpulse;
  end

  // Registered read drive so data outputs come from flip-flops.
  logic [7:0] rdata, next_rdata;
  logic       oe, next_oe;
  always_comb begin
    next_oe    = rd_act & block_select_in & ~rst_all;
    next_rdata = read_data_in;
  end
  always_ff @(posedge mclk_in) begin
    oe    <= next_oe;
    rdata <= next_rdata;
  end

  // Outputs into the programmable logic and the pins.
  assign pld_addr_out            = addr;
  assign pld_ctrl_out            = {fe_s, rd_s, wr_s};
  assign generic_in_out          = fe_s;
  assign read_active_out         = rd_act & ~rst_all;
  assign fetch_active_out        = ~fe_s & ~rst_all;
  assign write_data_out          = wdata;
  assign write_pulse_out         = wpulse;
  assign flash_abort_out         = rst_all & flash_busy_in;
  assign port_reset_out          = rst_all;
  assign bus.lower_addr_data_port_d = rdata;
  assign bus.upper_addr_data_port_d = `MBFE_DATA_RST;
  assign bus.data_oe_d           = oe;
endmodule

// File: rtl/mbfe_host.sv
// Host end: drives address, strobes and data onto the bus.
`timescale 1ns/10ps
`include "mbfe_map.svh"
module mbfe_host (
  // Clock and reset.
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  // Bus pins.
  mbfe_bus_if.host                bus,
  // User request side.
  input  wire mbfe_pkg::mbfe_host_t host_type_in,
  input  wire logic               req_in,
  input  wire logic               req_write_in,
  input  wire logic               req_fetch_in,
  input  wire logic [15:0]        req_addr_in,
  input  wire logic [7:0]         req_wdata_in,
  input  wire logic               dev_reset_n_in,
  output logic                    busy_out,
  output logic                    done_out,
  output logic [7:0]              rdata_out
);
  mbfe_pkg::mbfe_state_t st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [15:0] a, next_a;
  logic [7:0]  d, next_d, rd, next_rd;
  logic        w, next_w, f, next_f, dn, next_dn;
  logic [7:0]  lo1, lo2;

  // Read data passes two flops before use since it is a pin.
  always_ff @(posedge mclk_in) begin
    lo1 <= bus.lower_addr_data_port_d;
    lo2 <= lo1;
  end

  // Each phase is held sixteen cycles to cover the device synchronisers.
  always_comb begin
    next_st  = st;
    next_cnt = cnt + 4'h1;
    next_a   = a;
    next_d   = d;
    next_w   = w;
    next_f   = f;
    next_rd  = rd;
    next_dn  = 1'b0;
    case (st)
      mbfe_pkg::MBFE_IDLE: begin
        next_cnt = 4'h0;
        if (req_in) begin
          next_a  = req_addr_in;
          next_d  = req_wdata_in;
          next_w  = req_write_in;
          next_f  = req_fetch_in;
          next_st = mbfe_pkg::MBFE_ADDR;
        end
      end
      mbfe_pkg::MBFE_ADDR: begin
        if (cnt == 4'hf) begin
          next_cnt = 4'h0;
          next_st  = w ? mbfe_pkg::MBFE_WR : mbfe_pkg::MBFE_RD;
        end
      end
      mbfe_pkg::MBFE_RD: begin
        if (cnt == 4'hf) begin
          next_rd = lo2;
          next_dn = 1'b1;
          next_st = mbfe_pkg::MBFE_IDLE;
        end
      end
      mbfe_pkg::MBFE_WR: begin
        if (cnt == 4'hf) begin
          next_dn = 1'b1;
          next_st = mbfe_pkg::MBFE_IDLE;
        end
      end
      default: next_st = mbfe_pkg::MBFE_IDLE;
    endcase
    if (rst_in) begin
      next_st  = mbfe_pkg::MBFE_IDLE;
      next_cnt = 4'h0;
      next_rd  = `MBFE_DATA_RST;
      next_dn  = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st  <= next_st;
    cnt <= next_cnt;
    a   <= next_a;
    d   <= next_d;
    w   <= next_w;
    f   <= next_f;
    rd  <= next_rd;
    dn  <= next_dn;
  end

  logic in_addr, in_rd, in_wr, dirhost;
  assign in_addr = (st == mbfe_pkg::MBFE_ADDR);
  assign in_rd   = (st == mbfe_pkg::MBFE_RD);
  assign in_wr   = (st == mbfe_pkg::MBFE_WR);
  assign dirhost = (host_type_in == `MBFE_HOST_RW_DIR) ||
                   (host_type_in == `MBFE_HOST_DS);

  // Latch high during first half of address phase: falls mid-phase.
  assign bus.addr_latch = in_addr & ~cnt[3];
  // Low address on lower port, bits 8-15 on upper port.
  assign bus.lower_addr_data_port_h = in_wr ? d : a[7:0];
  assign bus.upper_addr_data_port_h = a[15:8];
  assign bus.lower_oe_h = in_addr | in_wr;
  assign bus.upper_oe_h = st != mbfe_pkg::MBFE_IDLE;
  // First control: write strobe, or direction high for read.
  assign bus.write_control_input = dirhost ? ~in_wr : ~in_wr;
  // Second control: data strobe, or read strobe for reads that are not fetches.
  assign bus.read_control_input = dirhost ? ~(in_rd | in_wr) :
                                  ~(in_rd & ~f);
  // Third control: fetch strobe, only for code reads.
  assign bus.fetch_control_input = ~(in_rd & f);
  assign bus.rst_n    = dev_reset_n_in;
  assign busy_out     = st != mbfe_pkg::MBFE_IDLE;
  assign done_out     = dn;
  assign rdata_out    = rd;
endmodule

// File: verif/mbfe_properties.sv
// Bus-level checks between the host and device ends.
`timescale 1ns/10ps
module mbfe_properties (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Bus signals.
  input wire logic lower_oe_h,
  input wire logic data_oe_d,
  input wire logic addr_latch,
  input wire logic write_control_input,
  input wire logic read_control_input,
  input wire logic fetch_control_input
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Reset must pull the device drivers off the port by the next cycle.
  AST_OE_RESET: assert property (disable iff (1'b0)
    rst_in |=> !data_oe_d) else $error("drive left on in reset");
  // Write control low with no fetch for five cycles means the port stays an input.
  AST_OE_NO_READ: assert property (
    (!write_control_input && fetch_control_input)[*5] |-> !data_oe_d)
    else $error("drive during write");
  // The strobe pin leads the drive by the two sync stages and the register.
  AST_OE_CAUSE: assert property (
    $rose(data_oe_d) |->
    $past(!read_control_input || !fetch_control_input, 3))
    else $error("drive without read");
  // Both ends driving the low port at once would short the lines.
  AST_NO_CLASH: assert property (!(lower_oe_h && data_oe_d))
    else $error("both ends drive low port");
  AST_LATCH_DRIVEN: assert property ($rose(addr_latch) |-> lower_oe_h)
    else $error("latch without address");
  AST_LATCH_LEN: assert property (
    $rose(addr_latch) |-> addr_latch[*8] ##1 !addr_latch)
    else $error("latch width wrong");
  AST_QUIET_ADDR: assert property ($fell(addr_latch) |->
    (read_control_input && fetch_control_input)[*8])
    else $error("strobe during address");
  AST_STROBE_LEN: assert property (
    $fell(read_control_input) |-> (!read_control_input)[*8])
    else $error("read strobe short");
  AST_LATCH_RESET: assert property (disable iff (1'b0)
    rst_in |=> !addr_latch) else $error("latch high in reset");
  // Main scenarios.
  cover property ($rose(data_oe_d));
  cover property ($rose(addr_latch));
  cover property ($fell(write_control_input));
endmodule

// File: verif/mcu_bus_front_end_tb.sv
// Testbench joining host and device ends of the bus front end.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module mcu_bus_front_end_tb;
  logic        mclk_in = 0, rst_in = 1, req = 0, wr = 0, fe = 0;
  logic        sty = 0, sel = 1, flash = 0, rstn = 1;
  logic [1:0]  ty = 2'h0;
  logic [15:0] addr = 16'h0000, pld_addr_out;
  logic [7:0]  wd = 8'h00, rd = 8'h00, write_data_out, rdata_out;
  logic        write_pulse_out, flash_abort_out, port_reset_out;
  logic        generic_in_out, busy_out, done_out;
  logic        read_active_out, fetch_active_out;
  logic        oe_q = 1'b0;
  logic [2:0]  pld_ctrl_out;
  int          failures = 0, compares = 0, cyc = 0, wp = 0, oe = 0, b;
  int          ra = 0, fa = 0, br, bf;
  mbfe_bus_if bus ();
  mbfe_device mbfe_device_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .bus(bus), .host_type_in(ty), .strobe_style_in(sty),
    .block_select_in(sel), .read_data_in(rd), .flash_busy_in(flash),
    .pld_addr_out(pld_addr_out), .write_data_out(write_data_out),
    .write_pulse_out(write_pulse_out), .read_active_out(read_active_out),
    .fetch_active_out(fetch_active_out), .generic_in_out(generic_in_out),
    .pld_ctrl_out(pld_ctrl_out), .flash_abort_out(flash_abort_out),
    .port_reset_out(port_reset_out));
  mbfe_host mbfe_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .bus(bus),
    .host_type_in(ty), .req_in(req), .req_write_in(wr), .req_fetch_in(fe),
    .req_addr_in(addr), .req_wdata_in(wd), .dev_reset_n_in(rstn),
    .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out));
  mbfe_properties mbfe_properties_inst (.mclk_in(mclk_in),
    .rst_in(rst_in), .lower_oe_h(bus.lower_oe_h),
    .data_oe_d(bus.data_oe_d), .addr_latch(bus.addr_latch),
    .write_control_input(bus.write_control_input),
    .read_control_input(bus.read_control_input),
    .fetch_control_input(bus.fetch_control_input));
  // Clock at 20 MHz.
  always #25 mclk_in = ~mclk_in;
  // Count write pulses, drive starts and cycles; a hang ends the run.
  always @(posedge mclk_in) begin
    cyc++;
    if (write_pulse_out === 1'b1) wp++;
    if (bus.data_oe_d === 1'b1 && oe_q === 1'b0) oe++;
    oe_q <= bus.data_oe_d;
    if (read_active_out === 1'b1) ra++;
    if (fetch_active_out === 1'b1) fa++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One whole host transfer; waits on done under a bound.
  task automatic op(input logic [1:0] t, input logic w, input logic f,
                    input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    ty <= t; wr <= w; fe <= f; addr <= a; wd <= d; req <= 1'b1;
    @(posedge mclk_in);
    req <= 1'b0;
    do begin @(posedge mclk_in); #1; n++; end
    while (done_out !== 1'b1 && n < 100);
    `CHK(done_out, 1'b1)
    // The write pulse trails the strobe by two sync stages and a register.
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  // Main sequence: writes per latch style, reads per host type, resets.
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk_in);
      sty <= s[0];
      b = wp;
      op(2'h0, 1'b1, 1'b0, 16'h12a5 + s, 8'h3c);
      `CHK(pld_addr_out, 16'h12a5 + s)
      `CHK(write_data_out, 8'h3c)
      `CHK(wp - b, 1)
    end
    `CHK(pld_ctrl_out, 3'h7)
    `CHK(generic_in_out, 1'b1)
    $display("test write done");
    for (int t = 0; t < 4; t++) begin
      @(posedge mclk_in);
      rd <= 8'(8'ha0 + t);
      b = oe;
      br = ra;
      bf = fa;
      op(t[1:0], 1'b0, t == 3, 16'h4400 + t, 8'h00);
      `CHK(rdata_out, 8'ha0 + t)
      `CHK(pld_addr_out, 16'h4400 + t)
      `CHK(oe - b, 1)
      `CHK(ra - br, 16)
      `CHK(fa - bf, (t == 3) ? 16 : 0)
    end
    @(posedge mclk_in);
    sel <= 1'b0;
    b = oe;
    op(2'h0, 1'b0, 1'b0, 16'h0081, 8'h00);
    `CHK(oe - b, 0)
    @(posedge mclk_in);
    sel <= 1'b1;
    $display("test read done");
    @(posedge mclk_in);
    flash <= 1'b1;
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK(flash_abort_out, 1'b1)
    `CHK(port_reset_out, 1'b1)
    `CHK(pld_addr_out, 16'h0000)
    @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    `CHK(flash_abort_out, 1'b0)
    op(2'h0, 1'b1, 1'b0, 16'h0f0f, 8'h11);
    `CHK(pld_addr_out, 16'h0f0f)
    `CHK(write_data_out, 8'h11)
    // The pin reset passes the two sync stages before it acts.
    @(posedge mclk_in);
    rstn <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    `CHK(pld_addr_out, 16'h0000)
    `CHK(port_reset_out, 1'b1)
    `CHK(flash_abort_out, 1'b1)
    @(posedge mclk_in);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk_in);
    #1;
    `CHK(port_reset_out, 1'b0)
    $display("test reset done");
    tally_and_finish();
  end
endmodule
